// ---- core/peru_top.sv ----
/*
 * PCI error report unit: event cause register with interrupt and
 * system-error masks, first-error capture and the command bits that
 * gate mastering and parity response, behind an AXI4-Lite slave.
 * Assumes the PCI core presents its signals on pins_i in the PCI clock
 * domain, holding them for a whole PCI clock period.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Target abort seen as master drives system error
// - Retry limit reached drives system error
// - Slave master abort, target abort drive error
// - Access and write protect violations drive error
// - Read buffer discard timeout drives system error
// - Broken master seen by arbiter drives error
// - System error only while its enable set
// - Low mask bits gate parity and abort events
// - Error captures address bits 31 to 0
// - Capture frozen until low address read
// - Error captures address bits 63 to 32
// - Error captures both data words
// - Command, byte enables and parities captured
// - Parity events set cause bits 0 to 6
// - Master failures set cause bits 8 to 11
// - Slave failures set cause bits 16 to 21
// - Self-test, power, reset set bits 24 to 26
// - Select field names the captured event
// - Write zero clears cause, one keeps it
// - Mask bit enables interrupt, resets to zero
// - Command bit 2 gates bus mastering
// - Command bit 6 gates parity response
module peru_top
   import peru_pkg::*;
(
   input  wire logic              clock_i,         // 200 MHz clock
   input  wire logic              rst_n_i,         // Async reset
   input  wire peru_pins_t        pins_i,          // PCI core signals
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   serr_n_o,        // Open-drain level
   output logic                   serr_oe_n_o,     // Low drives pin
   output logic                   irq_o,           // Error interrupt
   output logic                   bus_master_enable_o,
   output logic                   parity_response_enable_o
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      peru_pins_t        s1;          // Synchroniser first stage
      peru_pins_t        s2;          // Synchroniser second stage
      logic              pclk_d;      // Delayed PCI clock for edges
      logic              master_en;   // Command bit 2
      logic              perr_en;     // Command bit 6
      logic              serr_en;     // Command bit 8
      logic              sys_err;     // Status bit 30
      logic [NCAUSE-1:0] cause;       // Sticky event causes
      logic [4:0]        sel;         // Captured event code
      logic              held;        // Snapshot frozen
      peru_capture_t     cap;         // Snapshot
      logic [NCAUSE-1:0] irq_mask;    // Interrupt mask
      logic [NSERR-1:0]  serr_mask;   // System-error mask
      logic [ADDR_W-1:0] aw_addr;     // Held write address
      logic [DATA_W-1:0] w_data;      // Held write data
      logic [3:0]        w_strb;      // Held write strobes
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [DATA_W-1:0] rdata;
      logic              serr_oe_n;
      logic              irq;
   } peru_state_t;

   peru_state_t       q;              // Registered state
   peru_state_t       n;              // Next state
   logic [1:0]        rst_sync;       // Reset release stages
   logic              rst_q;          // Synchronised reset, active low
   logic              smp;            // PCI clock falling edge seen
   logic [NCAUSE-1:0] ev;             // Events taken this cycle
   logic [NCAUSE-1:0] clr;            // Cause bits cleared by write
   logic [DATA_W-1:0] wm;             // Write strobes per bit
   logic              rd_lo;          // Low address register read
   logic              wr_go;          // Write address and data held
   logic              serr;           // System error condition
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_q);      // Checks idle while in reset

   // Lowest numbered event present gives the select code
   function automatic logic [4:0] first_event(input logic [NCAUSE-1:0] v);
      logic [4:0] code;
      code = 5'h00;
      for (int i = NCAUSE - 1; i >= 0; i--) begin
         if (v[i]) begin
            code = 5'(i);
         end
      end
      return code;
   endfunction

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   // Assert at once, release after two clean edges
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q = rst_sync[1];

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      n     = q;
      clr   = '0;
      rd_lo = 1'b0;
      // Pins pass two flops; only the second stage is looked at
      n.s1     = pins_i;
      n.s2     = q.s1;
      n.pclk_d = q.s2.pclk;
      // Sample mid-period, on the PCI clock falling edge
      smp = q.pclk_d & ~q.s2.pclk;
      ev  = smp ? (q.s2.event_set & CAUSE_IMPL) : '0;
      // Slave, self-test, power and reset events as above
      // Attempt to master counts only while mastering is off
      ev[MTRY_BIT] = smp & q.s2.event_set[MTRY_BIT] & ~q.master_en;
      for (int b = 0; b < 4; b++) begin
         wm[8*b +: 8] = {8{q.w_strb[b]}};
      end

      // Read channel: one read at a time
      if (q.rvalid && s_axi_rready) begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end
      if (q.arready && s_axi_arvalid) begin
         n.arready = 1'b0;
         n.rvalid  = 1'b1;
         n.rresp   = RESP_OKAY;
         n.rdata   = '0;
         case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            OFF_STATUS_CMD: begin
               n.rdata[MASTER_EN_BIT]  = q.master_en;
               n.rdata[PAR_RESP_BIT]   = q.perr_en;
               n.rdata[SYS_ERR_EN_BIT] = q.serr_en;
               n.rdata[SYSERR_BIT] = q.sys_err;
            end
            OFF_SERR_MASK: n.rdata[NSERR-1:0] = q.serr_mask;
            OFF_ADDR_LO: begin
               n.rdata = q.cap.captured_address[31:0];
               rd_lo   = 1'b1;
            end
            OFF_ADDR_HI: n.rdata = q.cap.captured_address[63:32];
            OFF_DATA_LO: n.rdata = q.cap.captured_data[31:0];
            OFF_DATA_HI: n.rdata = q.cap.captured_data[63:32];
            OFF_CMD_CAP: begin
               n.rdata[CMD_LSB +: 4]   = q.cap.captured_command;
               n.rdata[BE_LSB +: 8]    = q.cap.captured_byte_enables;
               n.rdata[PAR_BIT]        = q.cap.captured_parity;
               n.rdata[PAR64_BIT]      = q.cap.captured_upper_parity;
            end
            OFF_CAUSE: n.rdata = {q.sel, q.cause};
            OFF_IRQ_MASK: n.rdata[NCAUSE-1:0] = q.irq_mask;
            default: n.rresp = RESP_SLVERR;
         endcase
      end

      // Write channel: address and data taken in either order
      if (q.bvalid && s_axi_bready) begin
         n.bvalid  = 1'b0;
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end
      if (q.awready && s_axi_awvalid) begin
         n.awready = 1'b0;
         n.aw_addr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         n.wready = 1'b0;
         n.w_data = s_axi_wdata;
         n.w_strb = s_axi_wstrb;
      end
      wr_go = ~q.awready & ~q.wready & ~q.bvalid;
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp  = RESP_OKAY;
         case ({q.aw_addr[ADDR_W-1:2], 2'h0})
            OFF_STATUS_CMD: begin
               if (wm[MASTER_EN_BIT]) begin
                  n.master_en = q.w_data[MASTER_EN_BIT];
               end
               if (wm[PAR_RESP_BIT]) begin
                  n.perr_en = q.w_data[PAR_RESP_BIT];
               end
               if (wm[SYS_ERR_EN_BIT]) begin
                  n.serr_en = q.w_data[SYS_ERR_EN_BIT];
               end
               if (wm[SYSERR_BIT] && q.w_data[SYSERR_BIT]) begin
                  n.sys_err = 1'b0;                   // Write one clears
               end
            end
            OFF_SERR_MASK: begin
               n.serr_mask = ((q.serr_mask & ~wm[NSERR-1:0])
                             | (q.w_data[NSERR-1:0] & wm[NSERR-1:0]))
                             & SERR_IMPL;
            end
            OFF_IRQ_MASK: begin
               n.irq_mask = ((q.irq_mask & ~wm[NCAUSE-1:0])
                            | (q.w_data[NCAUSE-1:0] & wm[NCAUSE-1:0]))
                            & CAUSE_IMPL;
            end
            OFF_CAUSE: clr = ~q.w_data[NCAUSE-1:0] & wm[NCAUSE-1:0];
            OFF_ADDR_LO, OFF_ADDR_HI, OFF_DATA_LO, OFF_DATA_HI,
            OFF_CMD_CAP: ; // Read-only, write ignored
            default: n.bresp = RESP_SLVERR;
         endcase
      end

      // Zero written clears, a new event in the same cycle wins
      n.cause = (q.cause & ~clr) | ev;

      // Snapshot loads only when free; reading low address frees it
      if (rd_lo) begin
         n.held = 1'b0;
      end
      if (!q.held && (ev != '0)) begin
         n.held = 1'b1;
         n.sel  = first_event(ev);
         n.cap.captured_address = q.s2.bus_addr;
         n.cap.captured_data    = q.s2.bus_data;
         n.cap.captured_command      = q.s2.bus_cmd;
         n.cap.captured_byte_enables = q.s2.bus_be;
         n.cap.captured_parity       = q.s2.bus_par;
         n.cap.captured_upper_parity = q.s2.bus_par64;
      end

      // System error: masked causes, gated by the enable bit
      serr = n.serr_en
             & ((n.cause[NSERR-1:0] & n.serr_mask) != '0);
      // Each masked bit feeds the OR above
      n.serr_oe_n = ~serr;
      if (serr) begin
         n.sys_err = 1'b1;
      end
      n.irq = (n.cause & n.irq_mask) != '0;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_q) begin
      if (!rst_q) begin
         q           <= '0;
         q.cause     <= CAUSE_RST;
         q.irq_mask  <= MASK_RST;
         q.serr_mask <= SMASK_RST;
         q.awready   <= 1'b1;
         q.wready    <= 1'b1;
         q.arready   <= 1'b1;
         q.serr_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign s_axi_awready            = q.awready;
   assign s_axi_wready             = q.wready;
   assign s_axi_bvalid             = q.bvalid;
   assign s_axi_bresp              = q.bresp;
   assign s_axi_arready            = q.arready;
   assign s_axi_rvalid             = q.rvalid;
   assign s_axi_rresp              = q.rresp;
   assign s_axi_rdata              = q.rdata;
   assign serr_n_o                 = q.sys_err & 1'b0; // Pin pulled low
   assign serr_oe_n_o              = q.serr_oe_n;
   assign irq_o                    = q.irq;
   assign bus_master_enable_o      = q.master_en;
   assign parity_response_enable_o = q.perr_en;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_tabort;
      (q.cause[9] && q.serr_mask[9] && q.serr_en) |-> !serr_oe_n_o;
   endproperty
   a_tabort: assert property (p_tabort)
      else $error("Target abort did not drive system error");
   property p_retry;
      (q.cause[11] && q.serr_mask[11] && q.serr_en) |-> !serr_oe_n_o;
   endproperty
   a_retry: assert property (p_retry)
      else $error("Retry limit did not drive system error");
   property p_slave_abort;
      ((q.cause[17:16] & q.serr_mask[17:16]) != 2'h0 && q.serr_en)
      |-> !serr_oe_n_o;
   endproperty
   a_slave_abort: assert property (p_slave_abort)
      else $error("Slave abort did not drive system error");
   property p_protect;
      ((q.cause[19:18] & q.serr_mask[19:18]) != 2'h0 && q.serr_en)
      |-> !serr_oe_n_o;
   endproperty
   a_protect: assert property (p_protect)
      else $error("Protect violation did not drive system error");
   property p_no_enable;
      !q.serr_en |-> serr_oe_n_o;
   endproperty
   a_no_enable: assert property (p_no_enable)
      else $error("System error driven while disabled");
   property p_hold;
      (q.held && !rd_lo) |=> $stable(q.cap) && $stable(q.sel);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Held snapshot changed before release");
   property p_event_sets;
      (smp && q.s2.event_set[0]) |=> q.cause[0] [*2];
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("Address parity event did not set cause");
   property p_irq;
      ((q.cause & q.irq_mask) != '0) |-> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Masked cause without interrupt");
   property p_sel;
      (!q.held && smp && q.s2.event_set[26] && q.s2.event_set[25:0] == '0)
      |=> q.held && q.sel == 5'h1A;
   endproperty
   a_sel: assert property (p_sel)
      else $error("Reset event not reported in select field");
   property p_master_gate;
      (q.master_en && !q.cause[MTRY_BIT]) |=> !q.cause[MTRY_BIT];
   endproperty
   a_master_gate: assert property (p_master_gate)
      else $error("Disabled-master cause set while enabled");
endmodule

`default_nettype wire

// ---- core/peru_pkg.sv ----
/*
 * Shared constants and types of the PCI error report unit: register
 * offsets, field positions, reset values and the packed carriers.
 * Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
 */
`default_nettype none

package peru_pkg;

   // ------------------------------------------------------------------
   // Bus widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 16;           // AXI byte address width
   localparam int DATA_W = 32;           // AXI data width
   localparam int NCAUSE = 27;           // Cause bits 26..0
   localparam int NSERR  = 22;           // System-error mask bits 21..0

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_STATUS_CMD = 16'h0004;
   localparam logic [ADDR_W-1:0] OFF_SERR_MASK  = 16'h0C28;
   localparam logic [ADDR_W-1:0] OFF_ADDR_LO    = 16'h1D40;
   localparam logic [ADDR_W-1:0] OFF_ADDR_HI    = 16'h1D44;
   localparam logic [ADDR_W-1:0] OFF_DATA_LO    = 16'h1D48;
   localparam logic [ADDR_W-1:0] OFF_DATA_HI    = 16'h1D4C;
   localparam logic [ADDR_W-1:0] OFF_CMD_CAP    = 16'h1D50;
   localparam logic [ADDR_W-1:0] OFF_CAUSE      = 16'h1D58;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 16'h1D5C;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int MASTER_EN_BIT  = 2;   // Bus master enable
   localparam int PAR_RESP_BIT   = 6;   // Parity response enable
   localparam int SYS_ERR_EN_BIT = 8;   // System error enable
   localparam int SYSERR_BIT  = 30;     // System error signalled flag
   localparam int SEL_LSB     = 27;     // Select field 31..27
   localparam int MTRY_BIT    = 10;     // Master attempt while disabled
   localparam int CMD_LSB     = 0;      // Captured command 3..0
   localparam int BE_LSB      = 8;      // Captured byte enables 15..8
   localparam int PAR_BIT     = 16;     // Captured parity
   localparam int PAR64_BIT   = 17;     // Captured upper parity

   // ------------------------------------------------------------------
   // Implemented bits and reset values
   // ------------------------------------------------------------------
   localparam logic [NCAUSE-1:0] CAUSE_IMPL = 27'h73F0F77;
   localparam logic [NSERR-1:0]  SERR_IMPL  = 22'h3F0B77;
   localparam logic [NCAUSE-1:0] CAUSE_RST  = 27'h0000000;
   localparam logic [NCAUSE-1:0] MASK_RST   = 27'h0000000;
   localparam logic [NSERR-1:0]  SMASK_RST  = 22'h000000;

   // ------------------------------------------------------------------
   // AXI responses
   // ------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Signals from the PCI core, all timed by the PCI clock
   typedef struct packed {
      logic              pclk;        // PCI clock as seen on the pin
      logic [NCAUSE-1:0] event_set;   // Event strobes, one per cause bit
      logic [63:0]       bus_addr;    // Address of current transaction
      logic [63:0]       bus_data;    // Data of current transaction
      logic [3:0]        bus_cmd;     // Bus command
      logic [7:0]        bus_be;      // Byte enables
      logic              bus_par;     // PAR
      logic              bus_par64;   // PAR64
   } peru_pins_t;

   // Error snapshot held for software
   typedef struct packed {
      logic [63:0] captured_address;
      logic [63:0] captured_data;
      logic [3:0]  captured_command;
      logic [7:0]  captured_byte_enables;
      logic        captured_parity;
      logic        captured_upper_parity;
   } peru_capture_t;

endpackage

`default_nettype wire

// ---- sim/peru_pci_model.sv ----
/*
 * PCI-side model for the error report unit: a free-running PCI clock
 * and one event strobe at a time with its transaction snapshot.
 * Assumes the unit samples the pins at the falling PCI clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module peru_pci_model
   import peru_pkg::*;
(
   output var peru_pins_t pins_o   // PCI core signals seen by the unit
);
   // ---------------------------------------------------------------
   // PCI clock, 160 ns period, free running, phase off the core clock
   // ---------------------------------------------------------------
   initial begin
      pins_o = '0;
      #3;
      forever #80 pins_o.pclk = ~pins_o.pclk;
   end
   // ---------------------------------------------------------------
   // One event for one whole PCI period, snapshot valid meanwhile
   // ---------------------------------------------------------------
   task automatic fire(input int b, input logic [63:0] a, d);
      @(posedge pins_o.pclk);
      pins_o.event_set    = '0;
      pins_o.event_set[b] = 1'b1;
      pins_o.bus_addr     = a;
      pins_o.bus_data     = d;
      pins_o.bus_cmd      = a[3:0];
      pins_o.bus_be       = d[7:0];
      pins_o.bus_par      = ^a;
      pins_o.bus_par64    = ^d;
      @(posedge pins_o.pclk);
      // Released address, data, command and byte-enable lines show the inverse; both parities keep their value
      pins_o.event_set    = '0;
      pins_o.bus_addr     = ~a;
      pins_o.bus_data     = ~d;
      pins_o.bus_cmd      = ~a[3:0];
      pins_o.bus_be       = ~d[7:0];
   endtask
endmodule
`default_nettype wire

// ---- sim/test_pci_error_report_unit.sv ----
/*
 * Self-checking bench of the PCI error report unit.
 * Assumes peru_top, peru_pkg and the PCI model peru_pci_model.
 */
`timescale 1ns/1ps
`default_nettype none
module test_pci_error_report_unit;
   import peru_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              clock_i, rst_n_i, irq_o, serr_n_o, serr_oe_n_o;
   logic              bus_master_enable_o, parity_response_enable_o;
   peru_pins_t        pins_i;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_rready, s_axi_rvalid;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic              s_axi_arready;
   logic [33:0]       exp_q[$];          // Expected {resp, data}
   int                error_cnt = 0;
   int                num_checks = 0;
   logic [31:0]       seed = 32'h00006A14;
   int evl[19] = '{0,1,2,4,5,6,8,9,10,11,16,17,18,19,20,21,24,25,26};

   peru_top u_dut (.clock_i, .rst_n_i, .pins_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .serr_n_o, .serr_oe_n_o, .irq_o, .bus_master_enable_o,
      .parity_response_enable_o);
   peru_pci_model u_pci (.pins_o(pins_i));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus answers are compared here against the oldest note
   always @(posedge clock_i) begin
      if (s_axi_bvalid && s_axi_bready) begin
         chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
      end
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      @(posedge clock_i);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clock_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 100) begin error_cnt++; stop_test(); end
   endtask
   task automatic rd(input logic [15:0] a, input logic [33:0] e);
      int n;
      @(posedge clock_i);
      exp_q.push_back(e);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clock_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 100) begin error_cnt++; stop_test(); end
   endtask
   task automatic wait_irq();
      int n;
      for (n = 0; n < 400 && irq_o !== 1'b1; n++) @(posedge clock_i);
      if (n == 400) begin error_cnt++; stop_test(); end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [63:0] a, d;
      logic [26:0] m;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0;
      s_axi_wstrb = 4'hF; rst_n_i = 1'b0;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rd(OFF_IRQ_MASK, 34'h0);
      rd(OFF_ADDR_LO, 34'h0);
      chk({irq_o, serr_oe_n_o, bus_master_enable_o}, 34'h2);
      wr(16'h0100, 32'h0, RESP_SLVERR);
      rd(16'h0100, {RESP_SLVERR, 32'h0});
      wr(OFF_STATUS_CMD, 32'h00000144, RESP_OKAY);
      rd(OFF_STATUS_CMD, {RESP_OKAY, 32'h00000144});
      chk({bus_master_enable_o, parity_response_enable_o},
          34'h3);
      // Attempt to master is not recorded while mastering is on
      u_pci.fire(10, '0, '0);
      rd(OFF_CAUSE, 34'h0);
      wr(OFF_STATUS_CMD, 32'h00000100, RESP_OKAY);
      wr(OFF_SERR_MASK, '1, RESP_OKAY);
      rd(OFF_SERR_MASK, {RESP_OKAY, 10'h0, SERR_IMPL});
      wr(OFF_IRQ_MASK, '1, RESP_OKAY);
      // Every event in turn, handler reads the low address last
      foreach (evl[i]) begin
         a = {xs(), xs()};
         d = {xs(), xs()};
         m = 27'h1 << evl[i];
         u_pci.fire(evl[i], a, d);
         wait_irq();
         chk(serr_oe_n_o,
             {33'h0, !(evl[i] < 22 && evl[i] != 10)});
         wr(OFF_CAUSE, '1, RESP_OKAY);
         rd(OFF_CAUSE,
            {RESP_OKAY, 5'(evl[i]), m});
         rd(OFF_CMD_CAP,
            {RESP_OKAY, 14'h0, ^d, ^a, d[7:0], 4'h0, a[3:0]});
         rd(OFF_ADDR_HI, {RESP_OKAY, a[63:32]});
         rd(OFF_DATA_LO, {RESP_OKAY, d[31:0]});
         rd(OFF_DATA_HI, {RESP_OKAY, d[63:32]});
         rd(OFF_ADDR_LO, {RESP_OKAY, a[31:0]});
         wr(OFF_CAUSE, ~{5'h0, m}, RESP_OKAY);
         repeat (2) @(posedge clock_i);
         chk({irq_o, serr_oe_n_o}, 34'h1);
      end
      // System error flag was raised above; writing one clears it
      rd(OFF_STATUS_CMD, {RESP_OKAY, 32'h40000100});
      wr(OFF_STATUS_CMD, 32'h40000100, RESP_OKAY);
      rd(OFF_STATUS_CMD, {RESP_OKAY, 32'h00000100});
      // Second error before the handler ran keeps the first snapshot
      u_pci.fire(16, a, d);
      u_pci.fire(17, ~a, ~d);
      repeat (4) @(posedge clock_i);
      rd(OFF_CAUSE, {RESP_OKAY, 5'd16, 27'h0030000});
      chk({serr_oe_n_o, serr_n_o}, 34'h0);
      rd(OFF_ADDR_LO, {RESP_OKAY, a[31:0]});
      wr(OFF_CAUSE, 32'h0, RESP_OKAY);
      // System error stays off without its enable, mask kills irq
      wr(OFF_STATUS_CMD, 32'h0, RESP_OKAY);
      u_pci.fire(9, a, d);
      wait_irq();
      chk(serr_oe_n_o, 34'h1);
      // Only the strobed low byte of the mask is written
      s_axi_wstrb <= 4'h1;
      wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      rd(OFF_IRQ_MASK, {RESP_OKAY, 5'h0, CAUSE_IMPL & 27'h7FFFF00});
      s_axi_wstrb <= 4'hF;
      wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clock_i);
      chk(irq_o, 34'h0);
      stop_test();
   end
endmodule
`default_nettype wire
